/* dcb_pkg.sv */
package dcb_pkg;

  // widths
  localparam int DCB_DATA_W = 16;
  localparam int DCB_ADDR_W = 16;
  localparam int DCB_CNT_W = 10;
  localparam int DCB_AXI_AW = 8;

  // register byte offsets
  localparam logic [DCB_AXI_AW-1:0] DCB_OFF_CTRL = 8'h00;
  localparam logic [DCB_AXI_AW-1:0] DCB_OFF_REQSEL = 8'h04;
  localparam logic [DCB_AXI_AW-1:0] DCB_OFF_COUNT = 8'h08;
  localparam logic [DCB_AXI_AW-1:0] DCB_OFF_PRI = 8'h0c;
  localparam logic [DCB_AXI_AW-1:0] DCB_OFF_SEC = 8'h10;
  localparam logic [DCB_AXI_AW-1:0] DCB_OFF_PADDR = 8'h14;
  localparam logic [DCB_AXI_AW-1:0] DCB_OFF_STAT = 8'h18;

  // channel_control_reg fields; mode field is bits 2:1
  localparam int DCB_CTRL_EN_BIT = 0;
  localparam int DCB_CTRL_ONESHOT_BIT = 1;
  localparam int DCB_CTRL_PP_BIT = 2;
  localparam int DCB_CTRL_DIR_BIT = 3;
  localparam int DCB_CTRL_NULL_WRITE_SELECT_BIT = 4;

  // request_select_reg and controller_status_zero fields
  localparam int DCB_REQ_FORCE_BIT = 0;
  localparam int DCB_STAT_XCOL_BIT = 0;
  localparam int DCB_STAT_PCOL_BIT = 1;
  localparam int DCB_STAT_BUSY_BIT = 2;
  localparam int DCB_STAT_BUF_BIT = 8;
  localparam int DCB_STAT_CNT_LSB = 16;

  // reset values
  localparam logic [DCB_ADDR_W-1:0] DCB_RST_ADDR = 16'h0000;
  localparam logic [DCB_CNT_W-1:0] DCB_RST_CNT = 10'h000;

  localparam logic [1:0] DCB_RESP_OKAY = 2'b00;
  localparam logic [1:0] DCB_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    DCB_ST_IDLE,
    DCB_ST_SRC,
    DCB_ST_WAIT,
    DCB_ST_DST
  } dcb_xfer_st_t;

  typedef struct packed {
    logic null_write_select;
    logic dir;
    logic pp;
    logic oneshot;
    logic en;
  } dcb_ctrl_t;

  // strobe group towards the peripheral bus or the dual-port RAM
  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [DCB_ADDR_W-1:0] addr;
    logic [DCB_DATA_W-1:0] wdata;
  } dcb_port_t;

endpackage

/* dcb_sequencer.sv */
`timescale 1ns/1ps

module dcb_sequencer
  import dcb_pkg::*;
#(
  parameter int CNT_W = DCB_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [DCB_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [DCB_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic periph_req,
  input wire logic [DCB_DATA_W-1:0] periph_rdata,
  input wire logic [DCB_DATA_W-1:0] ram_rdata,
  output dcb_port_t periph_o,
  output dcb_port_t ram_o,
  output logic block_done
);

  generate
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
      $error("CNT_W must lie between 1 and 16");
    end
  endgenerate

  typedef struct packed {
    dcb_ctrl_t ctrl;
    logic force_req;
    logic [CNT_W-1:0] blk_len;
    logic [DCB_ADDR_W-1:0] pri;
    logic [DCB_ADDR_W-1:0] sec;
    logic [DCB_ADDR_W-1:0] paddr;
    logic xcol;
    logic pcol;
    logic buf_sel;
    logic [CNT_W-1:0] cnt;
    logic pend;
    logic forced;
    dcb_xfer_st_t st;
    logic [DCB_DATA_W-1:0] data;
    dcb_port_t per;
    dcb_port_t ram;
    logic done;
    logic aw_got;
    logic w_got;
    logic [DCB_AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dcb_state_t;

  dcb_state_t s_reg;
  dcb_state_t s_next;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [DCB_AXI_AW-1:0] word_of(
      input logic [DCB_AXI_AW-1:0] a);
    return {a[DCB_AXI_AW-1:2], 2'b00};
  endfunction

  function automatic logic mapped(input logic [DCB_AXI_AW-1:0] a);
    logic [DCB_AXI_AW-1:0] w;
    w = word_of(a);
    return w == DCB_OFF_CTRL || w == DCB_OFF_REQSEL ||
           w == DCB_OFF_COUNT || w == DCB_OFF_PRI ||
           w == DCB_OFF_SEC || w == DCB_OFF_PADDR || w == DCB_OFF_STAT;
  endfunction

  function automatic logic [DCB_ADDR_W-1:0] ram_addr(input dcb_state_t s);
    logic [DCB_ADDR_W-1:0] base;
    base = s.buf_sel ? s.sec : s.pri;
    return base + DCB_ADDR_W'(s.cnt);
  endfunction

  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign periph_o = s_reg.per;
  assign ram_o = s_reg.ram;
  assign block_done = s_reg.done;

  always_comb begin
    logic [31:0] m;
    logic [DCB_AXI_AW-1:0] wa;
    logic [DCB_AXI_AW-1:0] ra;
    logic was_en;
    m = 32'h0000_0000;
    wa = word_of(s_reg.awaddr);
    ra = word_of(s_axi_araddr);
    was_en = s_reg.ctrl.en;
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.per.rd_en = 1'b0;
    s_next.per.wr_en = 1'b0;
    s_next.ram.rd_en = 1'b0;
    s_next.ram.wr_en = 1'b0;

    // element transfer: source strobe, wait, destination strobe
    case (s_reg.st)
      DCB_ST_IDLE: begin
        // peripheral request wins over a stored manual request
        if (s_reg.ctrl.en && (s_reg.pend || s_reg.force_req)) begin
          s_next.forced = !s_reg.pend;
          s_next.pend = 1'b0;
          if (s_reg.ctrl.dir) begin
            s_next.per.rd_en = 1'b1;
            s_next.per.addr = s_reg.paddr;
            // with null_write_select set, every start also writes zero to paddr here
            if (s_reg.ctrl.null_write_select) begin
              s_next.per.wr_en = 1'b1;
              s_next.per.wdata = '0;
            end
          end else begin
            s_next.ram.rd_en = 1'b1;
            s_next.ram.addr = ram_addr(s_reg);
          end
          s_next.st = DCB_ST_SRC;
        end
      end
      DCB_ST_SRC: begin
        // peripheral data registers answer in the strobe cycle
        if (s_reg.ctrl.dir) begin
          s_next.data = periph_rdata;
        end
        s_next.st = DCB_ST_WAIT;
      end
      DCB_ST_WAIT: begin
        if (s_reg.ctrl.dir) begin
          s_next.ram.wr_en = 1'b1;
          s_next.ram.addr = ram_addr(s_reg);
          s_next.ram.wdata = s_reg.data;
        end else begin
          s_next.per.wr_en = 1'b1;
          s_next.per.addr = s_reg.paddr;
          s_next.per.wdata = ram_rdata;
        end
        s_next.st = DCB_ST_DST;
      end
      DCB_ST_DST: begin
        if (s_reg.forced) begin
          s_next.force_req = 1'b0;
        end
        if (s_reg.cnt == s_reg.blk_len) begin
          s_next.cnt = '0;
          s_next.done = 1'b1;
          if (s_reg.ctrl.pp) begin
            s_next.buf_sel = !s_reg.buf_sel;
          end else begin
            s_next.buf_sel = 1'b0;
          end
          // one-shot ping-pong stops only after the secondary buffer
          if (s_reg.ctrl.oneshot && (!s_reg.ctrl.pp || s_reg.buf_sel)) begin
            s_next.ctrl.en = 1'b0;
            s_next.buf_sel = 1'b0;
          end
        end else begin
          s_next.cnt = s_reg.cnt + CNT_W'(1);
        end
        s_next.st = DCB_ST_IDLE;
      end
      default: begin
        s_next.st = DCB_ST_IDLE;
      end
    endcase

    // a new request sets pend, even in the cycle one is served
    if (periph_req) begin
      s_next.pend = 1'b1;
    end

    // write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end

    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = mapped(s_reg.awaddr) ? DCB_RESP_OKAY : DCB_RESP_SLVERR;
      if (wa == DCB_OFF_CTRL) begin
        m = merge(32'(s_next.ctrl), s_reg.wdata, s_reg.wstrb);
        s_next.ctrl = m[4:0];
        was_en = s_next.ctrl.en && !s_reg.ctrl.en;
        if (was_en) begin
          s_next.cnt = '0;
          s_next.buf_sel = 1'b0;
        end
      end else if (wa == DCB_OFF_REQSEL) begin
        // only a one in the low lane has any effect
        if (s_reg.wstrb[0] && s_reg.wdata[DCB_REQ_FORCE_BIT]) begin
          if (s_reg.st != DCB_ST_IDLE) begin
            s_next.force_req = s_reg.force_req;
          end else if (s_reg.pend || periph_req) begin
            s_next.xcol = 1'b1;
            s_next.pcol = 1'b1;
          end else begin
            s_next.force_req = 1'b1;
          end
        end
      end else if (wa == DCB_OFF_COUNT) begin
        m = merge(32'(s_reg.blk_len), s_reg.wdata, s_reg.wstrb);
        s_next.blk_len = m[CNT_W-1:0];
      end else if (wa == DCB_OFF_PRI) begin
        m = merge(32'(s_reg.pri), s_reg.wdata, s_reg.wstrb);
        s_next.pri = m[DCB_ADDR_W-1:0];
      end else if (wa == DCB_OFF_SEC) begin
        m = merge(32'(s_reg.sec), s_reg.wdata, s_reg.wstrb);
        s_next.sec = m[DCB_ADDR_W-1:0];
      end else if (wa == DCB_OFF_PADDR) begin
        m = merge(32'(s_reg.paddr), s_reg.wdata, s_reg.wstrb);
        s_next.paddr = m[DCB_ADDR_W-1:0];
      end else if (wa == DCB_OFF_STAT) begin
        // collision flags clear on a written one
        if (s_reg.wstrb[0] && s_reg.wdata[DCB_STAT_XCOL_BIT]) begin
          s_next.xcol = 1'b0;
        end
        if (s_reg.wstrb[0] && s_reg.wdata[DCB_STAT_PCOL_BIT]) begin
          s_next.pcol = 1'b0;
        end
      end
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = mapped(s_axi_araddr) ? DCB_RESP_OKAY : DCB_RESP_SLVERR;
      s_next.rdata = 32'h0000_0000;
      if (ra == DCB_OFF_CTRL) begin
        s_next.rdata = 32'(s_reg.ctrl);
      end else if (ra == DCB_OFF_REQSEL) begin
        s_next.rdata[DCB_REQ_FORCE_BIT] = s_reg.force_req;
      end else if (ra == DCB_OFF_COUNT) begin
        s_next.rdata = 32'(s_reg.blk_len);
      end else if (ra == DCB_OFF_PRI) begin
        s_next.rdata = 32'(s_reg.pri);
      end else if (ra == DCB_OFF_SEC) begin
        s_next.rdata = 32'(s_reg.sec);
      end else if (ra == DCB_OFF_PADDR) begin
        s_next.rdata = 32'(s_reg.paddr);
      end else if (ra == DCB_OFF_STAT) begin
        s_next.rdata[DCB_STAT_XCOL_BIT] = s_reg.xcol;
        s_next.rdata[DCB_STAT_PCOL_BIT] = s_reg.pcol;
        s_next.rdata[DCB_STAT_BUSY_BIT] = s_reg.st != DCB_ST_IDLE;
        s_next.rdata[DCB_STAT_BUF_BIT] = s_reg.buf_sel;
        s_next.rdata[DCB_STAT_CNT_LSB +: CNT_W] = s_reg.cnt;
      end
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.blk_len <= CNT_W'(DCB_RST_CNT);
      s_reg.pri <= DCB_RST_ADDR;
      s_reg.sec <= DCB_RST_ADDR;
      s_reg.paddr <= DCB_RST_ADDR;
      s_reg.st <= DCB_ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

/* dcb_partner.sv */
`timescale 1ns/1ps
module dcb_partner
  import dcb_pkg::*;
(
  input wire logic aclk,
  input wire dcb_port_t periph_o,
  input wire dcb_port_t ram_o,
  output logic periph_req,
  output logic [DCB_DATA_W-1:0] periph_rdata,
  output logic [DCB_DATA_W-1:0] ram_rdata
);
  logic [DCB_DATA_W-1:0] mem [256];
  logic [DCB_DATA_W-1:0] src, last_rw, last_pw;
  logic [DCB_ADDR_W-1:0] last_ra, last_pa;
  int n_rw, n_pw;
  initial begin
    periph_req = 1'b0;
    ram_rdata = 16'h0000;
    src = 16'ha500;
    n_rw = 0;
    n_pw = 0;
    for (int i = 0; i < 256; i++) mem[i] = 16'h1000 + 16'(i);
  end
  // data is only valid while read; a moving pattern exposes late sampling
  assign periph_rdata = periph_o.rd_en ? src : ~src;
  always @(posedge aclk) begin
    ram_rdata <= ram_o.rd_en ? mem[ram_o.addr[7:0]] : ~ram_rdata;
    if (periph_o.rd_en) src <= src + 16'h0001;
    if (ram_o.wr_en) begin
      mem[ram_o.addr[7:0]] <= ram_o.wdata;
      last_ra <= ram_o.addr;
      last_rw <= ram_o.wdata;
      n_rw <= n_rw + 1;
    end
    if (periph_o.wr_en) begin
      last_pw <= periph_o.wdata;
      last_pa <= periph_o.addr;
      n_pw <= n_pw + 1;
    end
  end
  // one pulse per data item, as a receiver raises when data arrives
  task automatic req();
    @(posedge aclk);
    periph_req <= 1'b1;
    @(posedge aclk);
    periph_req <= 1'b0;
  endtask
endmodule

/* dcb_seq_monitor.sv */
`timescale 1ns/1ps
module dcb_seq_monitor
  import dcb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [DCB_DATA_W-1:0] periph_rdata,
  input wire logic [DCB_DATA_W-1:0] ram_rdata,
  input wire dcb_port_t periph_o,
  input wire dcb_port_t ram_o,
  input wire logic block_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  per_to_ram_a: assert property (periph_o.rd_en |-> ##2
    (ram_o.wr_en && ram_o.wdata == $past(periph_rdata, 2)))
    else $error("peripheral data not moved to ram");
  ram_to_per_a: assert property (ram_o.rd_en |-> ##2
    (periph_o.wr_en && periph_o.wdata == $past(ram_rdata)))
    else $error("ram data not moved to peripheral");
  null_zero_a: assert property (periph_o.rd_en && periph_o.wr_en
    |-> periph_o.wdata == 16'h0000) else $error("null write not zero");
  one_element_a: assert property (ram_o.wr_en |=> !ram_o.wr_en [*3])
    else $error("ram writes too close");
  done_cause_a: assert property ($rose(block_done) |->
    $past(ram_o.wr_en || (periph_o.wr_en && !periph_o.rd_en)))
    else $error("block end without element");
  done_pulse_a: assert property (block_done |=> !block_done)
    else $error("block end flag held");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp lost");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data lost");
  cover property (periph_o.rd_en && periph_o.wr_en);
  cover property (ram_o.rd_en);
  cover property (block_done);
endmodule

bind dcb_sequencer dcb_seq_monitor mon (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .periph_rdata, .ram_rdata, .periph_o, .ram_o, .block_done
);

/* dcb_tb.sv */
`timescale 1ns/1ps
module testbench
  import dcb_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, bry = 1'b1, rry = 1'b1;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, d;
  logic awr, wry, bv, arr, rv, preq, bdone;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] prd, rrd, es = 16'ha500;
  dcb_port_t po, ro;
  int n_fail = 0, total_checks = 0, n_done = 0, c;
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) if (bdone === 1'b1) n_done <= n_done + 1;
  dcb_sequencer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wry),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .periph_req(preq), .periph_rdata(prd),
    .ram_rdata(rrd), .periph_o(po), .ram_o(ro), .block_done(bdone));
  dcb_partner pm (.aclk(aclk), .periph_o(po), .ram_o(ro),
    .periph_req(preq), .periph_rdata(prd), .ram_rdata(rrd));
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tmo();
    n_fail++;
    $display("CHECK FAILED t=%0t timeout", $time);
    finish_test();
  endtask
  // handshakes are judged mid-cycle, so the edge that takes them is known
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ah, wh, bh;
    int n;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bh = 1'b0;
    n = 0;
    while (!bh && n < 40) begin
      @(negedge aclk);
      ah = awv & awr;
      wh = wv & wry;
      bh = bv & bry;
      if (bh) rsp = bresp;
      @(posedge aclk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
      n++;
    end
    if (!bh) tmo();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic ah, rh;
    int n;
    ara <= a;
    arv <= 1'b1;
    rh = 1'b0;
    n = 0;
    while (!rh && n < 40) begin
      @(negedge aclk);
      ah = arv & arr;
      rh = rv & rry;
      v = rdat;
      rsp = rresp;
      @(posedge aclk);
      if (ah) arv <= 1'b0;
      n++;
    end
    if (!rh) tmo();
  endtask
  // one element: trigger by enable write or by a request, then check it
  task automatic el(input logic k, input logic [31:0] v,
                    input logic [15:0] ea);
    int c0, n;
    c0 = pm.n_rw;
    n = 0;
    if (!k) wr(DCB_OFF_CTRL, v);
    else pm.req();
    while (pm.n_rw == c0 && n < 60) begin
      @(posedge aclk);
      n++;
    end
    if (pm.n_rw == c0) tmo();
    chk(32'(pm.last_ra), 32'(ea));
    chk(32'(pm.last_rw), 32'(es));
    es++;
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(DCB_OFF_CTRL, d);
    chk(d, 32'h0);
    chk(32'(rsp), 32'(DCB_RESP_OKAY));
    wr(DCB_OFF_PRI, 32'h20);
    chk(32'(rsp), 32'(DCB_RESP_OKAY));
    wr(DCB_OFF_SEC, 32'h40);
    wr(DCB_OFF_PADDR, 32'h77);
    wr(DCB_OFF_COUNT, 32'h1);
    pm.req();
    repeat (8) @(posedge aclk);
    chk(32'(pm.n_rw), 32'h0);
    el(1'b0, 32'h0d, 16'h20);
    el(1'b1, 32'h0, 16'h21);
    el(1'b1, 32'h0, 16'h40);
    wr(DCB_OFF_CTRL, 32'h0c);
    pm.req();
    wr(DCB_OFF_REQSEL, 32'h1);
    rd(DCB_OFF_STAT, d);
    chk(d, 32'h0001_0103);
    rd(DCB_OFF_REQSEL, d);
    chk(d, 32'h0);
    wr(DCB_OFF_STAT, 32'h3);
    rd(DCB_OFF_STAT, d);
    chk(d, 32'h0001_0100);
    el(1'b0, 32'h0d, 16'h20);
    el(1'b1, 32'h0, 16'h21);
    repeat (2) @(posedge aclk);
    chk(32'(n_done), 32'h2);
    wr(DCB_OFF_CTRL, 32'h1c);
    wr(DCB_OFF_REQSEL, 32'h1);
    wr(DCB_OFF_REQSEL, 32'h0);
    rd(DCB_OFF_REQSEL, d);
    chk(d, 32'h1);
    c = pm.n_pw;
    el(1'b0, 32'h1d, 16'h20);
    chk(32'(pm.last_pw), 32'h0);
    chk(32'(pm.n_pw - c), 32'h1);
    chk(32'(pm.last_pa), 32'h77);
    rd(DCB_OFF_REQSEL, d);
    chk(d, 32'h0);
    wr(DCB_OFF_COUNT, 32'h0);
    wr(DCB_OFF_CTRL, 32'h0c);
    pm.req();
    el(1'b0, 32'h0f, 16'h20);
    el(1'b1, 32'h0, 16'h40);
    rd(DCB_OFF_CTRL, d);
    chk(d, 32'h0e);
    c = pm.n_rw;
    pm.req();
    repeat (8) @(posedge aclk);
    chk(32'(pm.n_rw - c), 32'h0);
    el(1'b0, 32'h09, 16'h20);
    el(1'b1, 32'h0, 16'h20);
    rd(DCB_OFF_CTRL, d);
    chk(d, 32'h09);
    wr(DCB_OFF_CTRL, 32'h08);
    pm.req();
    el(1'b0, 32'h0b, 16'h20);
    rd(DCB_OFF_CTRL, d);
    chk(d, 32'h0a);
    wr(DCB_OFF_PRI, 32'h80);
    pm.req();
    c = pm.n_pw;
    wr(DCB_OFF_CTRL, 32'h01);
    repeat (10) @(posedge aclk);
    chk(32'(pm.last_pw), 32'h1080);
    chk(32'(pm.n_pw - c), 32'h1);
    chk(32'(pm.last_pa), 32'h77);
    c = pm.n_pw;
    wr(DCB_OFF_REQSEL, 32'h1);
    repeat (10) @(posedge aclk);
    chk(32'(pm.n_pw - c), 32'h1);
    chk(32'(pm.last_pw), 32'h1080);
    rd(DCB_OFF_REQSEL, d);
    chk(d, 32'h0);
    rd(8'h3c, d);
    chk(d, 32'h0);
    chk(32'(rsp), 32'(DCB_RESP_SLVERR));
    wr(8'h3c, 32'h1);
    chk(32'(rsp), 32'(DCB_RESP_SLVERR));
    finish_test();
  end
endmodule
